/* File: ifd_core.sv */
// Instruction format decoder and cycle sequencer for the 8-bit core
// What this block does
// - Every instruction is one 14-bit word: opcode part plus operand parts.
// - Each word falls into exactly one class: byte, bit, or literal/control.
// - Byte ops: destination bit 0 writes accumulator, 1 writes file register.
// - Register operand is seven bits, addressing 0x00 through 0x7F.
// - Bit ops affect only the selected bit of the 8-bit register; the core gives a one-hot bit_mask but writes all of alu_result.
// - Literal ops carry an 8-bit data or 11-bit address constant.
// - One instruction cycle lasts four oscillator periods; all timing follows it.
// - Skips taken and program counter changes take two cycles, second a no-op.
// - File-register instructions read, modify, then store, even when only writing.
// - Reading the port register during read-modify-write counts as a real read.
// - Don't-care bit positions are ignored, either value accepted.
// - Port reads for modify-rewrite return pin levels, not the output latch.
// - Writing the timer-zero count clears the prescaler when assigned to it.
module ifd_core
	import ifd_pkg::*;
#(
	parameter logic [IFD_FA_W-1:0] TMR_ADDR  = 7'h01,
	parameter logic [IFD_FA_W-1:0] PCL_ADDR  = 7'h02,
	parameter logic [IFD_FA_W-1:0] PORT_ADDR = 7'h05
)
(
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic [IFD_WORD_W-1:0] instr_word,
	input  wire logic [IFD_DATA_W-1:0] file_rdata,
	input  wire logic [IFD_DATA_W-1:0] alu_result,
	input  wire logic [IFD_DATA_W-1:0] port_pins,
	input  wire logic                  psc_on_timer,
	output logic                       fetch_req,
	output logic                       cycle_start,
	output ifd_class_t                 instr_class,
	output logic [IFD_FA_W-1:0]        file_addr,
	output logic                       dest_file,
	output logic [IFD_BIT_W-1:0]       bit_sel,
	output logic [IFD_DATA_W-1:0]      bit_mask,
	output logic [IFD_K8_W-1:0]        literal8,
	output logic [IFD_K11_W-1:0]       literal11,
	output logic                       file_rd_en,
	output logic [IFD_DATA_W-1:0]      rd_data,
	output logic                       port_read,
	output logic                       file_wr_en,
	output logic                       acc_wr_en,
	output logic [IFD_DATA_W-1:0]      wr_data,
	output logic                       psc_clear,
	output logic                       skip_taken,
	output logic                       pc_change,
	output logic                       nop_cycle
);

	typedef struct packed {
		logic [IFD_WORD_W-1:0] ir;
		logic [IFD_DATA_W-1:0] mask;
		logic                  flush;
		logic [IFD_DATA_W-1:0] pin_s1;
		logic [IFD_DATA_W-1:0] pin_s2;
		logic [IFD_DATA_W-1:0] operand;
		logic [IFD_DATA_W-1:0] wdata;
		logic                  rd_en;
		logic                  port_rd;
		logic                  wr_file;
		logic                  wr_acc;
		logic                  psc_clr;
		logic                  skip;
		logic                  pc_chg;
	} ifd_core_st_t;

	ifd_core_st_t st_r;
	ifd_core_st_t st_nxt;
	ifd_phase_t   phase;

	// Class from the top two bits alone, so every word lands in one class
	function automatic ifd_class_t cls_of(input logic [IFD_WORD_W-1:0] w);
		logic [1:0] top;
		top = w[IFD_TOP_HI:IFD_TOP_LO];
		if (top == IFD_TOP_BYTE)
			cls_of = IFD_CLS_BYTE;
		else if (top == IFD_TOP_BIT)
			cls_of = IFD_CLS_BIT;
		else
			cls_of = IFD_CLS_LIT;
	endfunction

	// One-hot mask of the selected bit position
	function automatic logic [IFD_DATA_W-1:0] mask_of(input logic [IFD_BIT_W-1:0] sel);
		mask_of = {{(IFD_DATA_W-1){1'b0}}, 1'b1} << sel;
	endfunction

	ifd_phase_gen u_phase (
		.clk    (clk),
		.resetn (resetn),
		.phase  (phase)
	);

	// Field decode of the held word
	ifd_class_t             cls;
	logic [3:0]             byte_op;
	logic [1:0]             bit_op;
	logic                   dbit;
	logic [IFD_FA_W-1:0]    fa;
	logic                   names_file;
	logic                   writes_file;
	logic                   writes_acc;
	logic                   loads_pc;
	logic                   cond_true;
	logic                   at_port;
	logic                   live;

	// Only opcode and operand fields are looked at; stray bits never matter
	always_comb
	begin
		cls     = cls_of(st_r.ir);
		byte_op = st_r.ir[IFD_OP_HI:IFD_OP_LO];
		bit_op  = st_r.ir[IFD_BOP_HI:IFD_BOP_LO];
		dbit    = st_r.ir[IFD_D_POS];
		fa      = st_r.ir[IFD_FA_HI:IFD_FA_LO];
		live    = !st_r.flush;
		// Control group and accumulator clear name no register
		names_file = (cls == IFD_CLS_BIT) ||
			((cls == IFD_CLS_BYTE) && !((byte_op == IFD_OP_CTRL) && !dbit) &&
			!((byte_op == IFD_OP_CLR) && !dbit));
		writes_file = ((cls == IFD_CLS_BYTE) && names_file && dbit) ||
			((cls == IFD_CLS_BIT) &&
			((bit_op == IFD_BOP_CLR) || (bit_op == IFD_BOP_SET)));
		writes_acc = ((cls == IFD_CLS_BYTE) && !dbit && (byte_op != IFD_OP_CTRL)) ||
			((cls == IFD_CLS_LIT) &&
			(st_r.ir[IFD_TOP_HI:IFD_TOP_LO] != IFD_TOP_JUMP));
		loads_pc = (st_r.ir[IFD_TOP_HI:IFD_TOP_LO] == IFD_TOP_JUMP) ||
			(st_r.ir[IFD_RL_HI:IFD_RL_LO] == IFD_RETLW_CODE) ||
			(st_r.ir == IFD_RETURN) || (st_r.ir == IFD_RETFIE) ||
			(writes_file && (fa == PCL_ADDR));
		cond_true = 1'b0;
		if ((cls == IFD_CLS_BYTE) && ((byte_op == IFD_OP_DECSZ) || (byte_op == IFD_OP_INCSZ)))
			cond_true = (alu_result == '0);
		else if ((cls == IFD_CLS_BIT) && (bit_op == IFD_BOP_TSTC))
			cond_true = ((st_r.operand & st_r.mask) == '0);
		else if ((cls == IFD_CLS_BIT) && (bit_op == IFD_BOP_TSTS))
			cond_true = ((st_r.operand & st_r.mask) != '0);
		at_port = names_file && (fa == PORT_ADDR);
	end

	// Quarter sequencing: Q1 decode, Q2 read, Q3 modify, Q4 store and fetch
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.pin_s1 = port_pins;
		st_nxt.pin_s2 = st_r.pin_s1;
		unique case (phase)
			IFD_Q1:
			begin
				st_nxt.rd_en = names_file && live;
			end
			IFD_Q2:
			begin
				st_nxt.rd_en   = 1'b0;
				// Pin level, not the latch, so inputs driven low write back low
				st_nxt.operand = at_port ? st_r.pin_s2 : file_rdata;
				st_nxt.port_rd = st_r.rd_en && at_port;
			end
			IFD_Q3:
			begin
				st_nxt.port_rd = 1'b0;
				st_nxt.wdata   = alu_result;
				st_nxt.wr_file = writes_file && live;
				st_nxt.wr_acc  = writes_acc && live;
				st_nxt.psc_clr = writes_file && live && (fa == TMR_ADDR) &&
					psc_on_timer;
				st_nxt.skip    = cond_true && live;
				st_nxt.pc_chg  = loads_pc && live;
			end
			IFD_Q4:
			begin
				st_nxt.wr_file = 1'b0;
				st_nxt.wr_acc  = 1'b0;
				st_nxt.psc_clr = 1'b0;
				st_nxt.skip    = 1'b0;
				st_nxt.pc_chg  = 1'b0;
				st_nxt.ir      = instr_word;
				st_nxt.mask    = mask_of(instr_word[IFD_BIT_HI:IFD_BIT_LO]);
				// Prefetched word is already in; mark its cycle as a no-op
				st_nxt.flush   = st_r.skip || st_r.pc_chg;
			end
		endcase
	end

	// State register; reset word decodes as a no-op
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r    <= '0;
			st_r.ir <= IFD_RESET_WORD;
		end
		else
			st_r <= st_nxt;
	end

	// Fetch handshake is combinational from the phase
	assign fetch_req   = (phase == IFD_Q4);
	assign cycle_start = (phase == IFD_Q1);

	// Operand fields straight from the held word
	assign instr_class = cls;
	assign file_addr   = fa;
	assign dest_file   = dbit;
	assign bit_sel     = st_r.ir[IFD_BIT_HI:IFD_BIT_LO];
	assign bit_mask    = st_r.mask;
	assign literal8    = st_r.ir[IFD_K8_W-1:0];
	assign literal11   = st_r.ir[IFD_K11_W-1:0];
	assign file_rd_en  = st_r.rd_en;
	assign rd_data     = st_r.operand;
	assign port_read   = st_r.port_rd;
	assign file_wr_en  = st_r.wr_file;
	assign acc_wr_en   = st_r.wr_acc;
	assign wr_data     = st_r.wdata;
	assign psc_clear   = st_r.psc_clr;
	assign skip_taken  = st_r.skip;
	assign pc_change   = st_r.pc_chg;
	assign nop_cycle   = st_r.flush;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Quarter walk and fetch spacing
	sequence s_walk;
		phase == IFD_Q2 ##1 phase == IFD_Q3 ##1 phase == IFD_Q4 ##1 phase == IFD_Q1;
	endsequence
	property p_quarter_walk;
		phase == IFD_Q1 |=> s_walk;
	endproperty
	a_quarter_walk: assert property (p_quarter_walk) else $error("phase walk broken");

	property p_fetch_period;
		fetch_req |=> !fetch_req [*3] ##1 fetch_req;
	endproperty
	a_fetch_period: assert property (p_fetch_period) else $error("fetch not every 4");

	property p_one_class;
		(instr_class == IFD_CLS_BYTE) == (st_r.ir[IFD_TOP_HI:IFD_TOP_LO] == IFD_TOP_BYTE) &&
		(instr_class == IFD_CLS_BIT) == (st_r.ir[IFD_TOP_HI:IFD_TOP_LO] == IFD_TOP_BIT);
	endproperty
	a_one_class: assert property (p_one_class) else $error("class decode wrong");

	property p_dest_route;
		(instr_class == IFD_CLS_BYTE) && (file_wr_en || acc_wr_en) |->
			(file_wr_en == dest_file) && (acc_wr_en == !dest_file);
	endproperty
	a_dest_route: assert property (p_dest_route) else $error("destination misrouted");

	// Read two quarters ahead of every file store
	sequence s_read_modify;
		file_rd_en ##1 !file_rd_en ##1 file_wr_en;
	endsequence
	property p_rmw_order;
		file_wr_en |-> $past(file_rd_en, 2) && phase == IFD_Q4;
	endproperty
	a_rmw_order: assert property (p_rmw_order) else $error("store without read");

	property p_rmw_follow;
		s_read_modify |-> !acc_wr_en;
	endproperty
	a_rmw_follow: assert property (p_rmw_follow) else $error("both destinations");

	property p_port_read;
		file_rd_en && (file_addr == PORT_ADDR) |=> port_read && (rd_data == $past(st_r.pin_s2));
	endproperty
	a_port_read: assert property (p_port_read) else $error("port read missed");

	property p_pin_level;
		port_read |-> rd_data == $past(st_r.pin_s2);
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("latch used not pins");

	property p_psc_clear;
		psc_clear |-> file_wr_en && (file_addr == TMR_ADDR) && $past(psc_on_timer);
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("bad prescaler clear");

	property p_bit_only;
		(instr_class == IFD_CLS_BIT) && file_wr_en |-> $onehot(bit_mask);
	endproperty
	a_bit_only: assert property (p_bit_only) else $error("bit mask not one-hot");

	property p_two_cycle;
		skip_taken || pc_change |=> nop_cycle [*4] ##1 !nop_cycle;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("second cycle not no-op");

	property p_flush_quiet;
		nop_cycle |-> !file_rd_en && !file_wr_en && !acc_wr_en && !psc_clear &&
			!skip_taken && !pc_change && !port_read;
	endproperty
	a_flush_quiet: assert property (p_flush_quiet) else $error("update in no-op cycle");

	// Only counting and bit-test ops have a condition; literals never skip
	property p_skip_source;
		skip_taken |-> instr_class != IFD_CLS_LIT;
	endproperty
	a_skip_source: assert property (p_skip_source) else $error("skip from literal op");

	// Literal and control words name no register, so no read is issued
	property p_lit_no_read;
		file_rd_en |-> instr_class != IFD_CLS_LIT;
	endproperty
	a_lit_no_read: assert property (p_lit_no_read) else $error("read for literal op");

endmodule

/* File: ifd_pkg.sv */
// Shared constants, field layout and types for the instruction format decoder
package ifd_pkg;

	// Word and field widths
	localparam int IFD_WORD_W  = 14;
	localparam int IFD_FA_W    = 7;
	localparam int IFD_DATA_W  = 8;
	localparam int IFD_BIT_W   = 3;
	localparam int IFD_K8_W    = 8;
	localparam int IFD_K11_W   = 11;

	// Field positions inside the instruction word
	localparam int IFD_TOP_HI  = 13;
	localparam int IFD_TOP_LO  = 12;
	localparam int IFD_OP_HI   = 11;
	localparam int IFD_OP_LO   = 8;
	localparam int IFD_D_POS   = 7;
	localparam int IFD_BOP_HI  = 11;
	localparam int IFD_BOP_LO  = 10;
	localparam int IFD_BIT_HI  = 9;
	localparam int IFD_BIT_LO  = 7;
	localparam int IFD_FA_HI   = 6;
	localparam int IFD_FA_LO   = 0;
	localparam int IFD_RL_HI   = 13;
	localparam int IFD_RL_LO   = 10;

	// Top two bits select the class
	localparam logic [1:0] IFD_TOP_BYTE = 2'h0;
	localparam logic [1:0] IFD_TOP_BIT  = 2'h1;
	localparam logic [1:0] IFD_TOP_JUMP = 2'h2;

	// Byte-oriented opcode codes that steer sequencing
	localparam logic [3:0] IFD_OP_CTRL  = 4'h0;
	localparam logic [3:0] IFD_OP_CLR   = 4'h1;
	localparam logic [3:0] IFD_OP_DECSZ = 4'hB;
	localparam logic [3:0] IFD_OP_INCSZ = 4'hF;

	// Bit-oriented opcode codes
	localparam logic [1:0] IFD_BOP_CLR  = 2'h0;
	localparam logic [1:0] IFD_BOP_SET  = 2'h1;
	localparam logic [1:0] IFD_BOP_TSTC = 2'h2;
	localparam logic [1:0] IFD_BOP_TSTS = 2'h3;

	// Control words that load the program counter, plus the reset word, which is a no-op
	localparam logic [3:0]  IFD_RETLW_CODE = 4'hD;
	localparam logic [13:0] IFD_RETURN     = 14'h0008;
	localparam logic [13:0] IFD_RETFIE     = 14'h0009;
	localparam logic [13:0] IFD_RESET_WORD = 14'h0000;

	// Oscillator periods per instruction cycle
	localparam int IFD_QUARTERS = 4;
	localparam int IFD_PH_W     = $clog2(IFD_QUARTERS);

	// Quarter phases, Gray coded along the cycle
	typedef enum logic [1:0] {
		IFD_Q1 = 2'h0,
		IFD_Q2 = 2'h1,
		IFD_Q3 = 2'h3,
		IFD_Q4 = 2'h2
	} ifd_phase_t;

	// Decoded instruction class
	typedef enum logic [1:0] {
		IFD_CLS_BYTE = 2'h0,
		IFD_CLS_BIT  = 2'h1,
		IFD_CLS_LIT  = 2'h2
	} ifd_class_t;

endpackage

/* File: ifd_phase_gen.sv */
// Divide-by-four quarter phase generator for the instruction cycle
module ifd_phase_gen
	import ifd_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	output ifd_phase_t phase
);

	typedef struct packed {
		ifd_phase_t ph;
	} ifd_ph_st_t;

	ifd_ph_st_t st_r;
	ifd_ph_st_t st_nxt;

	// Walk Q1..Q4 and wrap; one code changes per step
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r.ph)
			IFD_Q1: st_nxt.ph = IFD_Q2;
			IFD_Q2: st_nxt.ph = IFD_Q3;
			IFD_Q3: st_nxt.ph = IFD_Q4;
			IFD_Q4: st_nxt.ph = IFD_Q1;
		endcase
	end

	// Phase register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_r <= '{ph: IFD_Q1};
		else
			st_r <= st_nxt;
	end

	assign phase = st_r.ph;

endmodule

/* File: ifd_prog_mem.sv */
// Program memory model that hands instruction words to the core
module ifd_prog_mem
	import ifd_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  fetch_req,
	output logic      [IFD_WORD_W-1:0] instr_word
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [IFD_WORD_W-1:0] mem[0:255];
	logic [IFD_WORD_W-1:0] last_r;
	int                    n_loaded = 0;
	int                    rd_ptr   = 0;

	// Bench appends words in program order
	task automatic load(input logic [IFD_WORD_W-1:0] w);
		mem[n_loaded] = w;
		n_loaded++;
	endtask

	// Whole 14-bit word only in the fetch slot, inverted junk elsewhere
	always @*
	begin
		if (fetch_req !== 1'b1)
			instr_word = ~last_r;
		else if (rd_ptr < n_loaded)
			instr_word = mem[rd_ptr];
		else
			instr_word = IFD_RESET_WORD;
	end

	// Advance at the edge that takes the word
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			last_r <= '0;
		else if (fetch_req === 1'b1)
		begin
			last_r <= instr_word;
			if (rd_ptr < n_loaded)
				rd_ptr <= rd_ptr + 1;
		end
	end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the instruction format decoder
module tb_top
	import ifd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [6:0] TMR_A  = 7'h01;
	localparam logic [6:0] PCL_A  = 7'h02;
	localparam logic [6:0] PORT_A = 7'h05;

	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [13:0] instr_word;
	logic [7:0]  file_rdata = 8'h00;
	logic [7:0]  alu_result = 8'h00;
	logic [7:0]  port_pins = 8'h5A;
	logic        psc_on_timer = 1'b0;
	logic        fetch_req, cycle_start, dest_file, file_rd_en, port_read;
	logic        file_wr_en, acc_wr_en, psc_clear, skip_taken, pc_change, nop_cycle;
	ifd_class_t  instr_class;
	logic [6:0]  file_addr;
	logic [2:0]  bit_sel;
	logic [7:0]  bit_mask, literal8, rd_data, wr_data;
	logic [10:0] literal11;
	int          n_errors = 0;
	int          samples_checked = 0;

	ifd_core #(.TMR_ADDR(TMR_A), .PCL_ADDR(PCL_A), .PORT_ADDR(PORT_A)) ifd_core_inst (
		.clk(clk), .resetn(resetn), .instr_word(instr_word), .file_rdata(file_rdata),
		.alu_result(alu_result), .port_pins(port_pins), .psc_on_timer(psc_on_timer),
		.fetch_req(fetch_req), .cycle_start(cycle_start), .instr_class(instr_class),
		.file_addr(file_addr), .dest_file(dest_file), .bit_sel(bit_sel),
		.bit_mask(bit_mask), .literal8(literal8), .literal11(literal11),
		.file_rd_en(file_rd_en), .rd_data(rd_data), .port_read(port_read),
		.file_wr_en(file_wr_en), .acc_wr_en(acc_wr_en), .wr_data(wr_data),
		.psc_clear(psc_clear), .skip_taken(skip_taken), .pc_change(pc_change),
		.nop_cycle(nop_cycle));

	ifd_prog_mem prog_mem_inst (.clk(clk), .resetn(resetn), .fetch_req(fetch_req),
		.instr_word(instr_word));

	// 10 MHz oscillator
	always #50 clk = ~clk;

	// Compare tasks, one per result width
	task automatic chk1(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chkv(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One instruction cycle; e = {nop,rd,port,fwr,awr,psc,skip,pc}
	task automatic exec(input logic [13:0] w, input logic [7:0] rd, input logic [7:0] alu,
		input logic ps, input logic [7:0] e);
		int         n;
		ifd_class_t cls;
		begin
			cls = (w[13:12] == 2'h0) ? IFD_CLS_BYTE : (w[13:12] == 2'h1) ? IFD_CLS_BIT : IFD_CLS_LIT;
			prog_mem_inst.load(w);
			n = 0;
			while (fetch_req !== 1'b1 && n < 8)
			begin
				@(negedge clk);
				n++;
			end
			chk1("fetch_req", 1'b1, fetch_req);
			@(posedge clk);
			file_rdata <= rd;
			alu_result <= alu;
			psc_on_timer <= ps;
			@(negedge clk);
			chk1("cycle_start", 1'b1, cycle_start);
			chk1("nop_cycle", e[7], nop_cycle);
			chkv("instr_class", 32'(cls), 32'(instr_class));
			chkv("fields", 32'({w[6:0], w[7], w[9:7], w[7:0], w[10:0]}),
				32'({file_addr, dest_file, bit_sel, literal8, literal11}));
			@(negedge clk);
			chk1("file_rd_en", e[6], file_rd_en);
			if (cls == IFD_CLS_BIT)
				chkv("bit_mask", 32'(8'h01 << w[9:7]), 32'(bit_mask));
			@(negedge clk);
			chk1("port_read", e[5], port_read);
			if (e[6])
				chkv("rd_data", 32'((w[6:0] == PORT_A) ? port_pins : rd), 32'(rd_data));
			@(negedge clk);
			chk1("file_wr_en", e[4], file_wr_en);
			chk1("acc_wr_en", e[3], acc_wr_en);
			chk1("psc_clear", e[2], psc_clear);
			chk1("skip_taken", e[1], skip_taken);
			chk1("pc_change", e[0], pc_change);
			chk1("nop_cycle", e[7], nop_cycle);
			chk1("q4_start", 1'b0, cycle_start);
			if ((e[4] | e[3]) && cls != IFD_CLS_BIT)
				chkv("wr_data", 32'(alu), 32'(wr_data));
		end
	endtask

	// Reset held 12 cycles, idle outputs checked while held
	task automatic t_reset();
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk1("rst_fetch", 1'b0, fetch_req);
		chk1("rst_wr", 1'b0, file_wr_en | acc_wr_en | nop_cycle);
		@(posedge clk);
		resetn <= 1'b1;
	endtask

	// Byte ops at both ends of the address range, both destinations
	task automatic t_byte();
		exec(14'h077F, 8'h11, 8'h22, 1'b0, 8'h48);
		exec(14'h0780, 8'h33, 8'h44, 1'b0, 8'h50);
	endtask

	// Clear on the port reads pins first; accumulator clears with x bits
	task automatic t_port();
		exec(14'h0185, 8'h33, 8'h00, 1'b0, 8'h70);
		exec(14'h0100, 8'h33, 8'h00, 1'b0, 8'h08);
		exec(14'h017F, 8'h33, 8'h00, 1'b0, 8'h08);
	endtask

	// Prescaler clears only on a file write to the timer while assigned
	task automatic t_timer();
		exec(14'h0881, 8'h07, 8'h07, 1'b1, 8'h54);
		exec(14'h0881, 8'h07, 8'h07, 1'b0, 8'h50);
		exec(14'h0801, 8'h07, 8'h07, 1'b1, 8'h48);
	endtask

	// Every bit position set, one clear, then both bit tests
	task automatic t_bits();
		for (int b = 0; b < 8; b++)
			exec({4'h5, 3'(b), 7'h10}, 8'h00, 8'hA5, 1'b0, 8'h50);
		exec(14'h137F, 8'hFF, 8'hBF, 1'b0, 8'h50);
		exec(14'h1990, 8'hF7, 8'h00, 1'b0, 8'h42);
		exec(14'h0780, 8'h00, 8'h00, 1'b0, 8'h80);
		exec(14'h1D90, 8'hF7, 8'h00, 1'b0, 8'h40);
	endtask

	// Counting skips; a flushed port clear must not read the port
	task automatic t_skip();
		exec(14'h0B90, 8'h01, 8'h00, 1'b0, 8'h52);
		exec(14'h30A5, 8'h00, 8'h00, 1'b0, 8'h80);
		exec(14'h0F10, 8'hFE, 8'h01, 1'b0, 8'h48);
		exec(14'h0F10, 8'hFF, 8'h00, 1'b0, 8'h4A);
		exec(14'h0185, 8'h00, 8'h00, 1'b0, 8'h80);
	endtask

	// Literal ops and every program counter load, each with its flush
	task automatic t_ctrl();
		logic [13:0] pcw[6];
		logic [7:0]  pce[6];
		begin
			pcw = '{14'h2FFF, 14'h2000, 14'h345A, 14'h0008, 14'h0009, 14'h0782};
			pce = '{8'h01, 8'h01, 8'h09, 8'h01, 8'h01, 8'h51};
			exec(14'h30A5, 8'h00, 8'h5C, 1'b0, 8'h08);
			exec(14'h33A5, 8'h00, 8'h5C, 1'b0, 8'h08);
			exec(14'h3E01, 8'h00, 8'h9D, 1'b0, 8'h08);
			for (int i = 0; i < 6; i++)
			begin
				exec(pcw[i], 8'h00, 8'h00, 1'b0, pce[i]);
				exec(14'h077F, 8'h00, 8'h00, 1'b0, 8'h80);
			end
			exec(14'h0000, 8'h00, 8'h00, 1'b0, 8'h00);
		end
	endtask

	// Main sequence
	initial
	begin
		t_reset();
		t_byte();
		t_port();
		t_timer();
		t_bits();
		t_skip();
		t_ctrl();
		wrap_up();
	end

	// Watchdog well past the expected run of under two hundred clock cycles
	initial
	begin
		#(3000 * 100);
		n_errors++;
		wrap_up();
	end
endmodule
